/* File: poc_positioning_option_control.sv */
`timescale 1ns/10ps
module poc_positioning_option_control (
  input wire logic clock,
  input wire logic rst,
  input wire poc_pkg::poc_obj_req_t objReq,
  output logic [31:0] objReadData,
  output logic objValid,
  output logic objError,
  input wire poc_pkg::poc_cmd_t cmdIn,
  input wire logic setpointAccepted,
  input wire logic targetReached,
  input wire logic signed [31:0] rampOutput,
  input wire logic signed [31:0] actualPosition,
  input wire logic signed [31:0] rangeMin,
  input wire logic signed [31:0] rangeMax,
  input wire logic [31:0] feedValue [3],
  output logic [31:0] feedConstant [3],
  output logic signed [31:0] absTarget,
  output logic targetValid,
  output logic moveDirPositive,
  output logic newSetpointClear,
  output logic setpointAck
);
  logic [15:0] option_reg;
  logic [31:0] shaftRev_reg [3];
  logic signed [31:0] prevTarget_reg;
  logic hasTarget_reg;
  logic nsPrev_reg;
  logic pendingRelease_reg;
  logic signed [31:0] relBase;
  logic signed [31:0] newTarget;
  logic signed [31:0] wrapped;
  logic signed [31:0] span;
  logic signed [31:0] diff;
  logic [1:0] relField;
  logic [1:0] releaseField;
  logic [1:0] rotField;
  logic nsRise;
  logic entryHit;
  logic [1:0] entrySel;

  assign relField = option_reg[poc_pkg::REL_LSB +: 2];
  assign releaseField = option_reg[poc_pkg::RELEASE_LSB +: 2];
  assign rotField = option_reg[poc_pkg::ROT_LSB +: 2];
  assign nsRise = cmdIn.newSetpoint & ~nsPrev_reg;
  assign span = rangeMax - rangeMin;
  assign entryHit = (objReq.subIndex >= 8'h01) && (objReq.subIndex <= poc_pkg::FEEDBACK_COUNT);
  assign entrySel = 2'(objReq.subIndex - 8'h01);

  // option word storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      option_reg <= poc_pkg::OPTION_RESET;
    end else if (objReq.write && objReq.index == poc_pkg::OPTION_INDEX
                 && objReq.subIndex == 8'h00) begin
      option_reg <= objReq.data[15:0];
    end
  end

  // revolution array storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < poc_pkg::NUM_FEEDBACK; i++) begin
        shaftRev_reg[i] <= poc_pkg::SHAFT_REV_RESET;
      end
    end else if (objReq.write && objReq.index == poc_pkg::SHAFT_REV_INDEX && entryHit) begin
      shaftRev_reg[entrySel] <= objReq.data;
    end
  end

  // object read answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      objReadData <= 32'h00000000;
      objValid <= 1'b0;
      objError <= 1'b0;
    end else begin
      objValid <= objReq.read | objReq.write;
      objError <= 1'b0;
      objReadData <= 32'h00000000;
      if (objReq.index == poc_pkg::SHAFT_REV_INDEX && objReq.subIndex == 8'h00) begin
        objReadData <= {24'h000000, poc_pkg::FEEDBACK_COUNT};
        objError <= objReq.write;
      end else if (objReq.index == poc_pkg::SHAFT_REV_INDEX && entryHit) begin
        objReadData <= shaftRev_reg[entrySel];
      end else if (objReq.index == poc_pkg::OPTION_INDEX && objReq.subIndex == 8'h00) begin
        objReadData <= {16'h0000, option_reg};
      end else begin
        objError <= objReq.read | objReq.write;
      end
    end
  end

  // feed constants, zero divisor gives zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < poc_pkg::NUM_FEEDBACK; i++) begin
        feedConstant[i] <= 32'h00000000;
      end
    end else begin
      for (int i = 0; i < poc_pkg::NUM_FEEDBACK; i++) begin
        feedConstant[i] <= (shaftRev_reg[i] == 32'h00000000) ? 32'h00000000
                           : feedValue[i] / shaftRev_reg[i];
      end
    end
  end

  // target computation
  always_comb begin
    relBase = prevTarget_reg;
    unique case (relField)
      2'b00: relBase = hasTarget_reg ? prevTarget_reg : 32'sh00000000;
      2'b01: relBase = rampOutput;
      2'b10: relBase = actualPosition;
      2'b11: relBase = hasTarget_reg ? prevTarget_reg : 32'sh00000000;
    endcase
    newTarget = cmdIn.relative ? relBase + cmdIn.target : cmdIn.target;
    wrapped = newTarget;
    if (rotField == 2'b00 && span > 32'sh00000000) begin
      if (newTarget >= rangeMax) begin
        wrapped = rangeMin + (newTarget - rangeMax);
      end else if (newTarget < rangeMin) begin
        wrapped = rangeMax - (rangeMin - newTarget);
      end
    end
    diff = wrapped - actualPosition;
  end

  // direction choice
  always_comb begin
    moveDirPositive = 1'b0;
    unique case (rotField)
      2'b00: moveDirPositive = (diff > 32'sh00000000);
      2'b01: moveDirPositive = 1'b0;
      2'b10: moveDirPositive = 1'b1;
      2'b11: begin
        if (diff < 32'sh00000000) begin
          moveDirPositive = ((diff + span) < (span >>> 1));
        end else begin
          moveDirPositive = (diff < (span >>> 1));
        end
      end
    endcase
  end

  // target latch on new setpoint edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prevTarget_reg <= 32'sh00000000;
      hasTarget_reg <= 1'b0;
      absTarget <= 32'sh00000000;
      targetValid <= 1'b0;
      nsPrev_reg <= 1'b0;
    end else begin
      nsPrev_reg <= cmdIn.newSetpoint;
      targetValid <= 1'b0;
      if (nsRise) begin
        prevTarget_reg <= wrapped;
        hasTarget_reg <= 1'b1;
        absTarget <= wrapped;
        targetValid <= 1'b1;
      end
    end
  end

  // setpoint release automation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pendingRelease_reg <= 1'b0;
      newSetpointClear <= 1'b0;
      setpointAck <= 1'b0;
    end else begin
      newSetpointClear <= 1'b0;
      if (nsRise) begin
        setpointAck <= 1'b1;
        pendingRelease_reg <= 1'b1;
      end else if (pendingRelease_reg) begin
        unique case (releaseField)
          2'b01: if (targetReached) begin
            newSetpointClear <= 1'b1;
            pendingRelease_reg <= 1'b0;
          end
          2'b10: if (setpointAccepted) begin
            newSetpointClear <= 1'b1;
            pendingRelease_reg <= 1'b0;
          end
          default: if (!cmdIn.newSetpoint) begin
            pendingRelease_reg <= 1'b0;
            setpointAck <= 1'b0;
          end
        endcase
      end else if (newSetpointClear || !cmdIn.newSetpoint) begin
        setpointAck <= 1'b0;
      end
    end
  end

  a_ack_after_clear: assert property (@(posedge clock) disable iff (rst)
    newSetpointClear && !nsRise |=> !setpointAck) else $error("ack not cleared");
  a_arrival_release: assert property (@(posedge clock) disable iff (rst)
    newSetpointClear && releaseField == 2'b01 |-> $past(targetReached))
    else $error("early release");
  a_asap_release: assert property (@(posedge clock) disable iff (rst)
    newSetpointClear && releaseField == 2'b10 |-> $past(setpointAccepted))
    else $error("release without accept");
  a_no_auto_clear: assert property (@(posedge clock) disable iff (rst)
    releaseField == 2'b00 && $past(releaseField) == 2'b00 |-> !newSetpointClear)
    else $error("auto clear in handshake mode");
  a_neg_only: assert property (@(posedge clock) disable iff (rst)
    rotField == 2'b01 |-> !moveDirPositive) else $error("positive in negative mode");
  a_pos_only: assert property (@(posedge clock) disable iff (rst)
    rotField == 2'b10 |-> moveDirPositive) else $error("negative in positive mode");
  a_target_latch: assert property (@(posedge clock) disable iff (rst)
    nsRise |=> targetValid && absTarget == $past(wrapped) && prevTarget_reg == absTarget)
    else $error("target lost");
  a_abs_move: assert property (@(posedge clock) disable iff (rst)
    nsRise && !cmdIn.relative && rotField != 2'b00 |=> absTarget == $past(cmdIn.target))
    else $error("absolute target changed");
  a_count_write: assert property (@(posedge clock) disable iff (rst)
    objReq.write && objReq.index == poc_pkg::SHAFT_REV_INDEX && objReq.subIndex == 8'h00
    |=> objError) else $error("count entry write accepted");
  a_count_value: assert property (@(posedge clock) disable iff (rst)
    objReq.read && objReq.index == poc_pkg::SHAFT_REV_INDEX && objReq.subIndex == 8'h00
    |=> objReadData == {24'h000000, poc_pkg::FEEDBACK_COUNT}) else $error("bad count");
  a_ack_set: assert property (@(posedge clock) disable iff (rst)
    nsRise |=> setpointAck) else $error("ack missing");
  a_feed_zero: assert property (@(posedge clock) disable iff (rst)
    shaftRev_reg[2] == 32'h00000000 |=> feedConstant[2] == 32'h00000000)
    else $error("zero divisor not caught");
  a_feed_divide: assert property (@(posedge clock) disable iff (rst)
    shaftRev_reg[0] != 32'h00000000
    |=> feedConstant[0] == $past(feedValue[0]) / $past(shaftRev_reg[0]))
    else $error("feed constant wrong");
  a_rel_ramp: assert property (@(posedge clock) disable iff (rst)
    nsRise && cmdIn.relative && relField == 2'b01 && newTarget == wrapped
    |=> absTarget == $past(rampOutput + cmdIn.target)) else $error("ramp base wrong");
  a_rel_actual: assert property (@(posedge clock) disable iff (rst)
    nsRise && cmdIn.relative && relField == 2'b10 && newTarget == wrapped
    |=> absTarget == $past(actualPosition + cmdIn.target)) else $error("actual base wrong");
  a_reserved_release: assert property (@(posedge clock) disable iff (rst)
    releaseField == 2'b11 && $past(releaseField) == 2'b11 |-> !newSetpointClear)
    else $error("auto clear in reserved mode");
endmodule

/* File: poc_pkg.sv */
package poc_pkg;
  localparam logic [15:0] SHAFT_REV_INDEX = 16'h60EE;
  localparam logic [15:0] OPTION_INDEX = 16'h60F2;
  localparam logic [7:0] FEEDBACK_COUNT = 8'h03;
  localparam int NUM_FEEDBACK = 3;
  localparam logic [31:0] SHAFT_REV_RESET = 32'h00000001;
  localparam logic [15:0] OPTION_RESET = 16'h0001;
  localparam int REL_LSB = 0;
  localparam int RELEASE_LSB = 4;
  localparam int ROT_LSB = 6;
  localparam int CW_RELATIVE_BIT = 6;
  localparam int CW_NEW_SETPOINT_BIT = 5;
  localparam int SW_ACK_BIT = 12;

  typedef enum logic [1:0] {
    REL_PREV_TARGET = 2'b00,
    REL_RAMP = 2'b01,
    REL_ACTUAL = 2'b10,
    REL_RESERVED = 2'b11
  } poc_rel_t;

  typedef enum logic [1:0] {
    REL_HANDSHAKE = 2'b00,
    REL_ON_ARRIVAL = 2'b01,
    REL_ASAP = 2'b10,
    REL_RESERVED2 = 2'b11
  } poc_release_t;

  typedef enum logic [1:0] {
    ROT_LINEAR = 2'b00,
    ROT_NEGATIVE = 2'b01,
    ROT_POSITIVE = 2'b10,
    ROT_SHORTEST = 2'b11
  } poc_rot_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] index;
    logic [7:0] subIndex;
    logic [31:0] data;
  } poc_obj_req_t;

  typedef struct packed {
    logic relative;
    logic newSetpoint;
    logic signed [31:0] target;
  } poc_cmd_t;
endpackage

/* File: poc_master_model.sv */
`timescale 1ns/10ps
module poc_master_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic drop,
  input wire logic relIn,
  input wire logic signed [31:0] targetIn,
  input wire logic newSetpointClear,
  output poc_pkg::poc_cmd_t cmd
);
  // target and mode held while new-setpoint stays high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd <= '0;
    end else if (go) begin
      cmd <= '{relative: relIn, newSetpoint: 1'b1, target: targetIn};
    end else if (drop || newSetpointClear) begin
      cmd.newSetpoint <= 1'b0;
    end
  end
endmodule

/* File: positioning_option_control_bench.sv */
`timescale 1ns/10ps
module positioning_option_control_bench;
  logic clock, rst, go, drop, relIn, setpointAccepted, targetReached, er;
  logic signed [31:0] targetIn, rampOutput, actualPosition, rangeMin, rangeMax, absTarget;
  logic [31:0] feedValue [3];
  logic [31:0] feedConstant [3];
  logic [31:0] objReadData, rd;
  logic objValid, objError, targetValid, moveDirPositive, newSetpointClear, setpointAck;
  logic [15:0] dOpt [5] = '{16'h0000, 16'h0040, 16'h0080, 16'h00C0, 16'h00C0};
  logic signed [31:0] dTgt [5] = '{32'h32, 32'h32, -32'sh32, 32'h32, -32'sh32};
  logic dExp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  poc_pkg::poc_obj_req_t objReq;
  poc_pkg::poc_cmd_t cmd;
  int err_count = 0;
  int checks_done = 0;
  poc_positioning_option_control u_poc_positioning_option_control (.clock(clock), .rst(rst),
    .objReq(objReq), .objReadData(objReadData), .objValid(objValid), .objError(objError),
    .cmdIn(cmd), .setpointAccepted(setpointAccepted), .targetReached(targetReached),
    .rampOutput(rampOutput), .actualPosition(actualPosition), .rangeMin(rangeMin),
    .rangeMax(rangeMax), .feedValue(feedValue), .feedConstant(feedConstant),
    .absTarget(absTarget), .targetValid(targetValid), .moveDirPositive(moveDirPositive),
    .newSetpointClear(newSetpointClear), .setpointAck(setpointAck));
  poc_master_model u_poc_master_model (.clock(clock), .rst(rst), .go(go), .drop(drop),
    .relIn(relIn), .targetIn(targetIn), .newSetpointClear(newSetpointClear), .cmd(cmd));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic obj(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] d);
    step;
    objReq = '{write: w, read: !w, index: idx, subIndex: sub, data: d};
    step;
    objReq = '0;
    rd = objReadData;
    er = objError;
    chk(objValid, 1);
  endtask
  task automatic move(input logic r, input logic signed [31:0] t, input logic signed [31:0] e);
    step;
    relIn = r;
    targetIn = t;
    go = 1;
    step;
    go = 0;
    step;
    chk(targetValid, 1);
    chk(absTarget, e);
    chk(setpointAck, 1);
  endtask
  // m: 0 master drops, 1 target reached, 2 setpoint accepted
  task automatic finish_move(input int m);
    logic seen;
    int n;
    seen = 0;
    step;
    drop = (m == 0);
    targetReached = (m == 1);
    setpointAccepted = (m == 2);
    for (n = 0; n < 20 && setpointAck !== 1'b0; n++) begin
      step;
      drop = 0;
      if (newSetpointClear === 1'b1) seen = 1;
    end
    chk(setpointAck, 0);
    if (n == 20) results;
    chk(seen, m != 0);
    chk(cmd.newSetpoint, 0);
    targetReached = 0;
    setpointAccepted = 0;
  endtask
  initial begin
    rst = 1; go = 0; drop = 0; relIn = 0; targetIn = 0; objReq = '0;
    setpointAccepted = 0; targetReached = 0; rampOutput = 32'h3E8; actualPosition = 32'h7D0;
    rangeMin = -32'sh186A0; rangeMax = 32'h186A0;
    feedValue = '{32'h78, 32'h5A, 32'h7};
    repeat (5) @(posedge clock);
    #1 rst = 0;
    obj(0, poc_pkg::SHAFT_REV_INDEX, 8'h00, 0);
    chk(rd, 32'h3);
    obj(1, poc_pkg::SHAFT_REV_INDEX, 8'h00, 32'h5);
    chk(er, 1);
    obj(0, poc_pkg::SHAFT_REV_INDEX, 8'h00, 0);
    chk(rd, 32'h3);
    obj(0, poc_pkg::OPTION_INDEX, 8'h00, 0);
    chk(rd, 32'h0001);
    for (int s = 1; s < 4; s++) begin
      obj(0, poc_pkg::SHAFT_REV_INDEX, 8'(s), 0);
      chk(rd, 32'h1);
      obj(1, poc_pkg::SHAFT_REV_INDEX, 8'(s), (s == 3) ? 32'h0 : 32'(5 - s));
      chk(er, 0);
    end
    obj(0, poc_pkg::SHAFT_REV_INDEX, 8'h02, 0);
    chk(rd, 32'h3);
    step;
    chk(feedConstant[0], 32'h1E);
    chk(feedConstant[1], 32'h1E);
    chk(feedConstant[2], 32'h0);
    obj(0, 16'h60EF, 8'h00, 0);
    chk(er, 1);
    chk(rd, 32'h0);
    $display("test objects done");
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0000);
    obj(0, poc_pkg::OPTION_INDEX, 8'h00, 0);
    chk(rd, 32'h0000);
    move(0, 32'h64, 32'h64);
    finish_move(0);
    move(1, 32'h7, 32'h6B);
    finish_move(0);
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0001);
    move(1, 32'h7, 32'h3EF);
    finish_move(0);
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0002);
    move(1, 32'h7, 32'h7D7);
    finish_move(0);
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0003);
    move(1, 32'h7, 32'h7DE);
    finish_move(0);
    $display("test relative done");
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0010);
    move(0, 32'h10, 32'h10);
    repeat (3) step;
    chk(setpointAck, 1);
    finish_move(1);
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0020);
    move(0, 32'h20, 32'h20);
    finish_move(2);
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0030);
    move(0, 32'h30, 32'h30);
    finish_move(0);
    $display("test release done");
    actualPosition = 0;
    for (int i = 0; i < 5; i++) begin
      obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'(dOpt[i]));
      move(0, dTgt[i], dTgt[i]);
      chk(moveDirPositive, dExp[i]);
      finish_move(0);
    end
    obj(1, poc_pkg::OPTION_INDEX, 8'h00, 32'h0000);
    move(0, 32'h186A5, -32'sh1869B);
    chk(moveDirPositive, 0);
    finish_move(0);
    move(0, -32'sh186A5, 32'h1869B);
    chk(moveDirPositive, 1);
    finish_move(0);
    $display("test direction done");
    results;
  end
endmodule
